/* common/iofc_pkg.sv */
package iofc_pkg;
    // link addressing
    localparam logic [5:0] DEV_ADDR_HI = 6'h08;
    localparam logic WR_BIT = 1'b0;
    localparam int NUM_FRAME_BYTES = 4;

    // pointer byte decode
    localparam logic [3:0] MODE_CONFIG = 4'h0;
    localparam logic [3:0] MODE_DAC_WRITE = 4'h1;
    localparam logic [3:0] PTR_NOP = 4'h0;
    localparam logic [3:0] PTR_BOOST = 4'h1;
    localparam logic [3:0] PTR_GEN_CTRL = 4'h3;
    localparam logic [3:0] PTR_SOFT_RESET = 4'hF;

    // pin function configuration registers
    localparam int NUM_PINS = 8;
    localparam int NUM_CFG = 8;
    localparam int CFG_ADC = 0;
    localparam int CFG_VDAC = 1;
    localparam int CFG_PULLDOWN = 2;
    localparam int CFG_GPIO_OUT = 3;
    localparam int CFG_GPIO_IN = 4;
    localparam int CFG_OPEN_DRAIN = 5;
    localparam int CFG_THREE_STATE = 6;
    localparam int CFG_IDAC = 7;
    localparam logic [NUM_CFG-1:0][3:0] CFG_PTR = {4'hE, 4'hD, 4'hC, 4'hA, 4'h8, 4'h6, 4'h5, 4'h4};
    localparam logic [NUM_CFG-1:0][7:0] CFG_RST = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    localparam logic [7:0] IDAC_PIN_MASK = 8'h0F;
    localparam logic [7:0] ALL_PINS = 8'hFF;

    // current output boost register
    localparam int NUM_IDAC = 4;
    localparam int BOOST_LSB = 5;
    localparam logic [NUM_IDAC-1:0] BOOST_RST = 4'h0;
    localparam logic [15:0] BOOST_WR_MASK = 16'h01E0;

    // general control register
    localparam int GEN_ADC_BUF = 9;
    localparam int GEN_LOCK = 7;
    localparam int GEN_WRITE_ALL = 6;
    localparam int GEN_ADC_RANGE = 5;
    localparam int GEN_DAC_RANGE = 4;
    localparam logic GEN_BIT_RST = 1'b0;
    localparam logic [15:0] GEN_WR_MASK = 16'h02F0;

    // host registers on apb
    localparam logic [31:0] HOST_CMD = 32'h0000_0000;
    localparam logic [31:0] HOST_DATA = 32'h0000_0004;
    localparam logic [31:0] HOST_STATUS = 32'h0000_0008;
    localparam logic [31:0] HOST_TARGET = 32'h0000_000C;
    localparam int CMD_GO_BIT = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_NACK = 2;

    typedef enum logic [2:0] {DS_ADDR, DS_PTR, DS_MSB, DS_LSB, DS_IGNORE} iofc_dev_state_type;
    typedef enum logic [1:0] {HS_IDLE, HS_SEND, HS_STOP} iofc_host_state_type;
endpackage

/* common/iofc_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface iofc_link_if;
    logic frame;
    logic byte_stb;
    logic [7:0] byte_data;
    logic byte_ack;
    logic byte_nack;

    modport dev (
        input frame,
        input byte_stb,
        input byte_data,
        output byte_ack,
        output byte_nack
    );

    modport host (
        output frame,
        output byte_stb,
        output byte_data,
        input byte_ack,
        input byte_nack
    );
endinterface
`default_nettype wire

/* rtl/iofc_pin_cfg.sv */
`timescale 1ns/10ps
`default_nettype none
module iofc_pin_cfg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // write side
    input wire logic wr_en,
    input wire logic lock,
    input wire logic [7:0] wr_data,
    // bitmap, bit n drives pin n
    output logic [7:0] value
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            value <= RESET_VALUE;
        end else if (wr_en && !lock) begin
            value <= wr_data;
        end
    end
endmodule
`default_nettype wire

/* rtl/iofc_device.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - boost bits 5..8 per current channel, reset 0
// - set boost raises channel full scale 10%
// - host writes zero to boost reserved bits
// - host writes zero to control reserved bits
// - control bit 9 enables ADC auxiliary buffer
// - control bit 7 freezes pin configuration registers
// - control bit 6 writes all DAC channels
// - control bit 5 doubles ADC input range
// - control bit 4 doubles DAC output range
// - data bit n maps to pin n
// - current output only on pins 0..3
// - pins default to pull-down after reset
// - DAC drive wins over GPIO out, pull-down and three-state, ADC may still sense
// - address byte, then pointer byte selects register
// - upper byte then lower byte form word
// - general control at pointer 0x03, reset 0
module iofc_device (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link to host
    iofc_link_if.dev link,
    // address strap
    input wire logic addr_a0,
    // current output full-scale raise
    output logic cur_out0_fullscale_raise,
    output logic cur_out1_fullscale_raise,
    output logic cur_out2_fullscale_raise,
    output logic cur_out3_fullscale_raise,
    // analog control
    output logic adc_aux_buffer_en,
    output logic config_locked,
    output logic adc_range_double,
    output logic dac_range_double,
    // pin functions, bit n is config_pin_n
    output logic [iofc_pkg::NUM_PINS-1:0] pin_dac_drive,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_current_out,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_adc_sense,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_pulldown,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_gpio_out,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_gpio_in,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_open_drain,
    output logic [iofc_pkg::NUM_PINS-1:0] pin_three_state,
    // dac data writes
    output logic dac_wr_stb,
    output logic [iofc_pkg::NUM_PINS-1:0] dac_wr_mask,
    output logic [15:0] dac_wr_word
);
    import iofc_pkg::*;

    iofc_dev_state_type state;
    logic [7:0] ptr;
    logic [7:0] msb;
    logic [15:0] word;
    logic addr_ok;
    logic commit;
    logic cfg_mode;
    logic soft_rst;
    logic rst_any;
    logic [NUM_CFG-1:0][7:0] cfg;
    logic [NUM_IDAC-1:0] boost;
    logic gen_adc_buf;
    logic gen_lock;
    logic gen_write_all;
    logic gen_adc_range;
    logic gen_dac_range;
    logic [7:0] idac_pins;
    logic [7:0] dac_pins;

    assign addr_ok = link.byte_data == {DEV_ADDR_HI, addr_a0, WR_BIT};
    assign commit = link.byte_stb && (state == DS_LSB);
    assign word = {msb, link.byte_data};
    assign cfg_mode = ptr[7:4] == MODE_CONFIG;
    assign soft_rst = commit && cfg_mode && (ptr[3:0] == PTR_SOFT_RESET);
    assign rst_any = srst || soft_rst;

    // byte answers, same cycle as the strobe
    assign link.byte_ack = link.byte_stb && ((state == DS_ADDR) ? addr_ok
        : (state == DS_PTR || state == DS_MSB || state == DS_LSB));
    assign link.byte_nack = link.byte_stb && !link.byte_ack;

    // frame sequencing: address, pointer, upper, lower
    always_ff @(posedge clk_sys) begin
        if (srst || !link.frame) begin
            state <= DS_ADDR;
        end else if (link.byte_stb) begin
            unique case (state)
                DS_ADDR: begin
                    state <= addr_ok ? DS_PTR : DS_IGNORE;
                end
                DS_PTR: begin
                    state <= DS_MSB;
                end
                DS_MSB: begin
                    state <= DS_LSB;
                end
                DS_LSB: begin
                    state <= DS_IGNORE;
                end
                DS_IGNORE: begin
                    state <= DS_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr <= 8'h00;
            msb <= 8'h00;
        end else if (link.byte_stb && state == DS_PTR) begin
            ptr <= link.byte_data;
        end else if (link.byte_stb && state == DS_MSB) begin
            msb <= link.byte_data;
        end
    end

    // boost register, reserved bits not stored
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            boost <= BOOST_RST;
        end else if (commit && cfg_mode && ptr[3:0] == PTR_BOOST) begin
            boost <= word[BOOST_LSB +: NUM_IDAC];
        end
    end

    // general control stays writable under lock so the lock can be lifted
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            gen_adc_buf <= GEN_BIT_RST;
            gen_lock <= GEN_BIT_RST;
            gen_write_all <= GEN_BIT_RST;
            gen_adc_range <= GEN_BIT_RST;
            gen_dac_range <= GEN_BIT_RST;
        end else if (commit && cfg_mode && ptr[3:0] == PTR_GEN_CTRL) begin
            gen_adc_buf <= word[GEN_ADC_BUF];
            gen_lock <= word[GEN_LOCK];
            gen_write_all <= word[GEN_WRITE_ALL];
            gen_adc_range <= word[GEN_ADC_RANGE];
            gen_dac_range <= word[GEN_DAC_RANGE];
        end
    end

    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
        iofc_pin_cfg #(
            .RESET_VALUE(CFG_RST[i])
        ) u_cfg (
            .clk_sys(clk_sys),
            .srst(rst_any),
            .wr_en(commit && cfg_mode && ptr[3:0] == CFG_PTR[i]),
            .lock(gen_lock),
            .wr_data(word[7:0]),
            .value(cfg[i])
        );
    end

    assign idac_pins = cfg[CFG_IDAC] & IDAC_PIN_MASK;
    assign dac_pins = cfg[CFG_VDAC] | idac_pins;

    assign adc_aux_buffer_en = gen_adc_buf;
    assign config_locked = gen_lock;
    assign adc_range_double = gen_adc_range;
    assign dac_range_double = gen_dac_range;

    // pin function decode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_dac_drive <= 8'h00;
            pin_current_out <= 8'h00;
            pin_adc_sense <= 8'h00;
            pin_pulldown <= CFG_RST[CFG_PULLDOWN];
            pin_gpio_out <= 8'h00;
            pin_gpio_in <= 8'h00;
            pin_open_drain <= 8'h00;
            pin_three_state <= 8'h00;
        end else begin
            pin_dac_drive <= dac_pins;
            pin_current_out <= idac_pins;
            pin_adc_sense <= cfg[CFG_ADC];
            pin_pulldown <= cfg[CFG_PULLDOWN] & ~dac_pins & ~cfg[CFG_GPIO_OUT]
                & ~cfg[CFG_THREE_STATE];
            pin_gpio_out <= cfg[CFG_GPIO_OUT] & ~dac_pins;
            pin_gpio_in <= cfg[CFG_GPIO_IN];
            pin_open_drain <= cfg[CFG_OPEN_DRAIN] & cfg[CFG_GPIO_OUT];
            pin_three_state <= cfg[CFG_THREE_STATE] & ~dac_pins;
        end
    end

    // boost acts only on enabled current outputs, pins 0..3
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur_out0_fullscale_raise <= 1'b0;
            cur_out1_fullscale_raise <= 1'b0;
            cur_out2_fullscale_raise <= 1'b0;
            cur_out3_fullscale_raise <= 1'b0;
        end else begin
            cur_out0_fullscale_raise <= boost[0] & idac_pins[0];
            cur_out1_fullscale_raise <= boost[1] & idac_pins[1];
            cur_out2_fullscale_raise <= boost[2] & idac_pins[2];
            cur_out3_fullscale_raise <= boost[3] & idac_pins[3];
        end
    end

    // dac data writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dac_wr_stb <= 1'b0;
            dac_wr_mask <= 8'h00;
            dac_wr_word <= 16'h0000;
        end else begin
            dac_wr_stb <= commit && (ptr[7:4] == MODE_DAC_WRITE);
            if (commit && ptr[7:4] == MODE_DAC_WRITE) begin
                dac_wr_mask <= gen_write_all ? ALL_PINS : (8'h01 << ptr[2:0]);
                dac_wr_word <= word;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/iofc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module iofc_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to device
    iofc_link_if.host link
);
    import iofc_pkg::*;

    iofc_host_state_type state;
    logic [7:0] cmd_ptr;
    logic [15:0] data_word;
    logic target_a0;
    logic done;
    logic nack;
    logic [31:0] shift;
    logic [1:0] cnt;
    logic busy;
    logic setup;
    logic wr;
    logic mapped;
    logic start;
    logic [15:0] sent_word;

    assign busy = state != HS_IDLE;
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign mapped = paddr == HOST_CMD || paddr == HOST_DATA || paddr == HOST_STATUS || paddr == HOST_TARGET;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign start = wr && paddr == HOST_CMD && pwdata[CMD_GO_BIT] && !busy;

    // reserved bits forced to zero
    always_comb begin
        sent_word = data_word;
        if (pwdata[7:0] == {MODE_CONFIG, PTR_BOOST}) begin
            sent_word = data_word & BOOST_WR_MASK;
        end else if (pwdata[7:0] == {MODE_CONFIG, PTR_GEN_CTRL}) begin
            sent_word = data_word & GEN_WR_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            if (paddr == HOST_CMD) begin
                prdata[7:0] <= cmd_ptr;
            end else if (paddr == HOST_DATA) begin
                prdata[15:0] <= data_word;
            end else if (paddr == HOST_STATUS) begin
                prdata[ST_NACK:ST_BUSY] <= {nack, done, busy};
            end else if (paddr == HOST_TARGET) begin
                prdata[0] <= target_a0;
            end
        end
    end

    // writes while busy are ignored
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_ptr <= 8'h00;
            data_word <= 16'h0000;
            target_a0 <= 1'b0;
        end else if (wr && !busy) begin
            if (paddr == HOST_CMD) begin
                cmd_ptr <= pwdata[7:0];
            end else if (paddr == HOST_DATA) begin
                data_word <= pwdata[15:0];
            end else if (paddr == HOST_TARGET) begin
                target_a0 <= pwdata[0];
            end
        end
    end

    // sticky flags, a set wins over a clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done <= 1'b0;
            nack <= 1'b0;
        end else begin
            if (state == HS_STOP) begin
                done <= 1'b1;
            end else if (wr && paddr == HOST_STATUS && pwdata[ST_DONE]) begin
                done <= 1'b0;
            end
            if (state == HS_SEND && link.byte_nack) begin
                nack <= 1'b1;
            end else if (wr && paddr == HOST_STATUS && pwdata[ST_NACK]) begin
                nack <= 1'b0;
            end
        end
    end

    // frame: address, pointer, upper byte, lower byte
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= HS_IDLE;
            shift <= 32'h0000_0000;
            cnt <= 2'h0;
        end else begin
            unique case (state)
                HS_IDLE: begin
                    if (start) begin
                        shift <= {DEV_ADDR_HI, target_a0, WR_BIT, pwdata[7:0], sent_word};
                        cnt <= 2'h0;
                        state <= HS_SEND;
                    end
                end
                HS_SEND: begin
                    if (link.byte_nack) begin
                        state <= HS_STOP;
                    end else if (link.byte_ack) begin
                        shift <= {shift[23:0], 8'h00};
                        cnt <= cnt + 2'h1;
                        if (cnt == 2'(NUM_FRAME_BYTES - 1)) begin
                            state <= HS_STOP;
                        end
                    end
                end
                HS_STOP: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.frame = state == HS_SEND;
    assign link.byte_stb = state == HS_SEND;
    assign link.byte_data = shift[31:24];
endmodule
`default_nettype wire

/* verification/iofc_link_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module iofc_link_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link
    input wire logic frame,
    input wire logic byte_stb,
    input wire logic [7:0] byte_data,
    input wire logic byte_ack,
    input wire logic byte_nack
);
    import iofc_pkg::*;
    logic [2:0] taken;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // bytes taken so far in the open frame
    always_ff @(posedge clk_sys) begin
        if (srst || !frame) begin
            taken <= 3'h0;
        end else if (byte_stb && taken != 3'h7) begin
            taken <= taken + 3'h1;
        end
    end
    chk_one_answer: assert property (byte_stb |-> byte_ack ^ byte_nack)
        else $error("ack and nack not exclusive");
    chk_stb_in_frame: assert property (byte_stb |-> frame)
        else $error("byte offered outside a frame");
    chk_frame_opens: assert property ($rose(frame) |-> byte_stb && taken == 3'h0)
        else $error("frame opened without address byte");
    chk_addr_byte: assert property (byte_stb && byte_ack && taken == 3'h0 |->
        byte_data[7:2] == DEV_ADDR_HI && byte_data[0] == WR_BIT)
        else $error("address byte acked with wrong value");
    chk_nack_holds: assert property (byte_stb && byte_nack |=> (frame && byte_stb) |-> byte_nack)
        else $error("byte acked after a nack");
    chk_next_byte: assert property (byte_stb && byte_ack && taken < 3'h3 |=> byte_stb)
        else $error("next byte not offered at once");
    chk_stop_after_four: assert property (byte_stb && byte_ack && taken == 3'h3 |=> !frame && !byte_stb)
        else $error("frame not closed after lower byte");
    chk_frame_bounded: assert property ($rose(frame) |-> ##[1:12] !frame)
        else $error("frame stays open too long");
    cov_full_frame: cover property (byte_stb && byte_ack && taken == 3'h3);
    cov_nack: cover property (byte_stb && byte_nack);
    cov_dac_ptr: cover property (byte_stb && byte_ack && taken == 3'h1 && byte_data[7:4] == MODE_DAC_WRITE);
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import iofc_pkg::*;
    localparam logic [7:0] P_CTRL = {MODE_CONFIG, PTR_GEN_CTRL};
    localparam logic [7:0] P_BOOST = {MODE_CONFIG, PTR_BOOST};
    localparam logic [7:0] P_VDAC = {MODE_CONFIG, CFG_PTR[CFG_VDAC]};
    localparam logic [7:0] P_ADC = {MODE_CONFIG, CFG_PTR[CFG_ADC]};
    localparam logic [7:0] P_IDAC = {MODE_CONFIG, CFG_PTR[CFG_IDAC]};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic addr_a0 = 1'b0;
    logic [31:0] prdata, rd, st;
    logic pready, pslverr, err;
    logic [3:0] raise;
    logic aux_en, locked, adc_dbl, dac_dbl, dac_wr_stb;
    logic [7:0] p_dac, p_cur, p_adc, p_pd, p_go, p_gi, p_od, p_ts, dac_wr_mask, mask_seen;
    logic [15:0] dac_wr_word, word_seen;
    logic [7:0] seen_q[$];
    int ctrl_bit[3] = '{GEN_ADC_BUF, GEN_ADC_RANGE, GEN_DAC_RANGE};
    int gp_idx[5] = '{CFG_GPIO_OUT, CFG_GPIO_IN, CFG_OPEN_DRAIN, CFG_THREE_STATE, CFG_PULLDOWN};
    logic [7:0] gp_val[5] = '{8'h33, 8'h0F, 8'h06, 8'h81, 8'h3F};
    int pulses = 0;
    int p0;
    int num_errors = 0;
    int total_checks = 0;

    iofc_link_if iofc_link_if_inst ();
    iofc_host iofc_host_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(iofc_link_if_inst.host));
    iofc_device iofc_device_inst (.clk_sys(clk_sys), .srst(srst), .link(iofc_link_if_inst.dev),
        .addr_a0(addr_a0), .cur_out0_fullscale_raise(raise[0]), .cur_out1_fullscale_raise(raise[1]),
        .cur_out2_fullscale_raise(raise[2]), .cur_out3_fullscale_raise(raise[3]), .adc_aux_buffer_en(aux_en),
        .config_locked(locked), .adc_range_double(adc_dbl), .dac_range_double(dac_dbl),
        .pin_dac_drive(p_dac), .pin_current_out(p_cur), .pin_adc_sense(p_adc), .pin_pulldown(p_pd),
        .pin_gpio_out(p_go), .pin_gpio_in(p_gi), .pin_open_drain(p_od), .pin_three_state(p_ts),
        .dac_wr_stb(dac_wr_stb), .dac_wr_mask(dac_wr_mask), .dac_wr_word(dac_wr_word));
    iofc_link_sva iofc_link_sva_inst (.clk_sys(clk_sys), .srst(srst), .frame(iofc_link_if_inst.frame),
        .byte_stb(iofc_link_if_inst.byte_stb), .byte_data(iofc_link_if_inst.byte_data),
        .byte_ack(iofc_link_if_inst.byte_ack), .byte_nack(iofc_link_if_inst.byte_nack));

    always #10 clk_sys = ~clk_sys;

    // dac pulse capture and link byte log
    always @(posedge clk_sys) begin
        if (dac_wr_stb === 1'b1) begin
            pulses++;
            mask_seen = dac_wr_mask;
            word_seen = dac_wr_word;
        end
        if (iofc_link_if_inst.frame === 1'b1 && iofc_link_if_inst.byte_stb === 1'b1) begin
            seen_q.push_back(iofc_link_if_inst.byte_data);
        end
    end

    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask

    // one link frame, waits for done or nack, then clears both
    task dev_write(input logic [7:0] ptr, input logic [15:0] word);
        int n;
        seen_q.delete();
        apb(1'b1, HOST_DATA, {16'h0000, word});
        apb(1'b1, HOST_CMD, (32'h1 << CMD_GO_BIT) | {24'h0, ptr});
        n = 0;
        do begin
            apb(1'b0, HOST_STATUS, 32'h0);
            st = rd;
            n++;
        end while (!(st[ST_BUSY] === 1'b0 && (st[ST_DONE] | st[ST_NACK]) === 1'b1) && n < 40);
        if (st[ST_BUSY] !== 1'b0 || (st[ST_DONE] | st[ST_NACK]) !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        apb(1'b1, HOST_STATUS, (32'h1 << ST_DONE) | (32'h1 << ST_NACK));
    endtask

    task cfg(input logic [7:0] ptr, input logic [15:0] word);
        logic [31:0] got;
        dev_write(ptr, word);
        got = 32'hXXXXXXXX;
        if (seen_q.size() == 4) begin
            got = {seen_q[0], seen_q[1], seen_q[2], seen_q[3]};
        end
        check("frame bytes", got, {DEV_ADDR_HI, addr_a0, WR_BIT, ptr, word});
        check("nack bit", st[ST_NACK], 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        check("pulldown", p_pd, 8'hFF);
        check("pin maps", {p_dac, p_cur, p_adc, p_go, p_gi, p_od, p_ts}, 56'h0);
        check("ctrl outs", {raise, aux_en, locked, adc_dbl, dac_dbl}, 8'h00);
        apb(1'b0, 32'h0000_0010, 32'h0);
        check("unmapped", {err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            cfg(P_CTRL, 16'h0001 << ctrl_bit[i]);
            check("ctrl bit", {aux_en, adc_dbl, dac_dbl, locked}, {3'b100 >> i, 1'b0});
        end
        cfg(P_IDAC, 16'h00F9);
        check("current pins", p_cur, 8'h09);
        cfg(P_BOOST, 16'h01E0);
        check("boost all", raise, 4'h9);
        cfg(P_BOOST, 16'h0100);
        check("boost upper", raise, 4'h8);
        dev_write(P_BOOST, 16'hFFFF);
        check("boost mask", {seen_q[2], seen_q[3], raise}, {16'h01E0, 4'h9});
        // current pins 0 and 3 stay in the dac drive map
        cfg(P_VDAC, 16'h0082);
        check("vdac pins", p_dac, 8'h8B);
        cfg(P_ADC, 16'h0082);
        check("dac and adc", {p_dac, p_adc}, 16'h8B82);
        cfg(P_CTRL, 16'h0080);
        check("lock on", locked, 1'b1);
        cfg(P_VDAC, 16'h0001);
        check("locked pins", p_dac, 8'h8B);
        cfg(P_CTRL, 16'h0000);
        check("lock off", locked, 1'b0);
        cfg(P_VDAC, 16'h0001);
        check("unlocked pins", p_dac, 8'h09);
        for (int wa = 1; wa >= 0; wa--) begin
            cfg(P_CTRL, wa[0] ? 16'h0040 : 16'h0000);
            p0 = pulses;
            cfg({MODE_DAC_WRITE, 4'h2}, 16'h0ABC);
            check("dac write", {pulses - p0, mask_seen, word_seen}, {32'd1, wa[0] ? 8'hFF : 8'h04, 16'h0ABC});
        end
        apb(1'b1, HOST_TARGET, 32'h1);
        dev_write(P_VDAC, 16'h00FF);
        check("wrong address", {st[ST_NACK], p_dac}, {1'b1, 8'h09});
        addr_a0 <= 1'b1;
        cfg(P_VDAC, 16'h0010);
        check("strap one", p_dac, 8'h19);
        // gpio out, gpio in, open drain, three-state, pull-down against dac pins 0x19
        for (int k = 0; k < 5; k++) begin
            cfg({MODE_CONFIG, CFG_PTR[gp_idx[k]]}, {8'h00, gp_val[k]});
        end
        check("gpio pins", {p_go, p_gi, p_od, p_ts, p_pd}, 40'h220F028004);
        cfg(P_CTRL, 16'h02B0);
        check("ctrl set", {aux_en, locked, adc_dbl, dac_dbl}, 4'hF);
        dev_write(P_CTRL, 16'hFFBF);
        check("ctrl mask", {seen_q[2], seen_q[3], aux_en, locked, adc_dbl, dac_dbl}, {16'h02B0, 4'hF});
        cfg({MODE_CONFIG, PTR_SOFT_RESET}, 16'h0000);
        check("soft reset", {raise, aux_en, locked, adc_dbl, dac_dbl, p_dac, p_cur, p_pd}, 32'h0000_00FF);
        stop_test();
    end
endmodule
`default_nettype wire
